/* mifd_decode.sv */
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module mifd_decode
  import mifd_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic [mifd_pkg::INSN_W-1:0]   insn,
  input  wire logic [mifd_pkg::DATA_W-1:0]   w_in,
  input  wire logic                          carry_in,
  input  wire logic [mifd_pkg::DATA_W-1:0]   file_rdata,
  input  wire logic [mifd_pkg::DATA_W-1:0]   port_pins,
  output logic                               insn_fetch,
  output logic                               phase_end,
  output mifd_pkg::mifd_fields_s             fields,
  output logic                               file_rd,
  output logic [mifd_pkg::ADDR_W-1:0]        file_addr,
  output mifd_pkg::mifd_wb_s                 wb,
  output logic                               carry_out,
  output logic                               pc_load,
  output logic                               skip_next,
  output logic                               nop_cycle,
  output logic                               port_a_read
);
  import mifd_pkg::*;

  // ------------------------------------------------------------------
  // Clock phases
  // ------------------------------------------------------------------
  logic [1:0] phase;
  logic       flush;
  logic       next_flush;

  wire cyc_end = (phase == PH_LAST);
  wire cyc_beg = (phase == PH_RST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PH_RST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // Field split
  // ------------------------------------------------------------------
  wire [1:0]         grp_code = insn[GRP_LSB +: 2];
  wire [ADDR_W-1:0]  f_addr   = insn[ADDR_LSB +: ADDR_W];
  wire               d_bit    = insn[DEST_POS];
  wire [BITN_W-1:0]  b_num    = insn[BITN_LSB +: BITN_W];
  wire [3:0]         byte_op  = insn[BYOP_LSB +: 4];
  wire [1:0]         bit_op   = insn[BOP_LSB +: 2];
  wire [LIT8_W-1:0]  lit8     = insn[0 +: LIT8_W];
  wire [LIT11_W-1:0] lit11    = insn[0 +: LIT11_W];

  wire is_byte = (grp_code == GRP_BYTE);
  wire is_bit  = (grp_code == GRP_BIT);
  wire is_lit  = grp_code[1];
  wire is_jump = (grp_code == GRP_JUMP);
  // All-zero upper byte op field with low bits is control, not a file access
  wire ctl_zero = is_byte && (byte_op == BY_MOVWF) && !d_bit;
  wire clrw     = is_byte && (byte_op == BY_CLR) && !d_bit;
  wire is_ret   = ctl_zero && ((f_addr == CTL_RETURN) || (f_addr == CTL_RETFIE));
  wire names_f  = (is_byte && !ctl_zero && !clrw) || is_bit;

  mifd_group_e grp_e;
  assign grp_e = is_byte ? MIFD_GRP_BYTE : (is_bit ? MIFD_GRP_BIT : MIFD_GRP_LIT);

  // ------------------------------------------------------------------
  // Read-modify-write data path
  // ------------------------------------------------------------------
  // Port reads see pins, not latch, so externally pulled bits write back
  wire is_port  = (f_addr == PORT_A_ADDR);
  wire [DATA_W-1:0] rd_val = is_port ? port_pins : file_rdata;
  wire [DATA_W-1:0] bmask  = 8'h01 << b_num;
  wire [DATA_W:0]   sum    = {1'b0, rd_val} + {1'b0, w_in};
  wire [DATA_W:0]   diff   = {1'b0, rd_val} + {1'b0, ~w_in} + 9'h001;
  wire [DATA_W-1:0] dec    = rd_val - 8'h01;
  wire [DATA_W-1:0] inc    = rd_val + 8'h01;

  logic [DATA_W-1:0] byte_res;
  logic              byte_c;
  always_comb begin
    byte_c = carry_in;
    case (byte_op)
      BY_MOVWF:  byte_res = w_in;
      BY_CLR:    byte_res = DATA_RST;
      BY_SUBWF:  begin byte_res = diff[DATA_W-1:0]; byte_c = diff[DATA_W]; end
      BY_DECF:   byte_res = dec;
      BY_IORWF:  byte_res = rd_val | w_in;
      BY_ANDWF:  byte_res = rd_val & w_in;
      BY_XORWF:  byte_res = rd_val ^ w_in;
      BY_ADDWF:  begin byte_res = sum[DATA_W-1:0]; byte_c = sum[DATA_W]; end
      BY_MOVF:   byte_res = rd_val;
      BY_COMF:   byte_res = ~rd_val;
      BY_INCF:   byte_res = inc;
      BY_DECFSZ: byte_res = dec;
      BY_RRF:    begin byte_res = {carry_in, rd_val[DATA_W-1:1]}; byte_c = rd_val[0]; end
      BY_RLF:    begin byte_res = {rd_val[DATA_W-2:0], carry_in}; byte_c = rd_val[DATA_W-1]; end
      BY_SWAPF:  byte_res = {rd_val[3:0], rd_val[7:4]};
      default:   byte_res = inc;
    endcase
  end

  wire [DATA_W-1:0] bit_res = (bit_op == BT_CLR) ? (rd_val & ~bmask) : (rd_val | bmask);
  wire bit_val  = |(rd_val & bmask);
  wire bit_wr   = is_bit && !bit_op[1];
  // Fixed-destination byte ops: store to file when d is set (CLR with d clear writes W); others follow the destination bit
  wire byte_fixed = (byte_op == BY_MOVWF) || (byte_op == BY_CLR);
  wire byte_fwr = is_byte && !ctl_zero && !clrw && (byte_fixed || d_bit);
  wire byte_wwr = (is_byte && !byte_fixed && !d_bit) || clrw;

  wire skip_hit = (is_byte && (byte_op == BY_DECFSZ) && (dec == DATA_RST))
               || (is_byte && (byte_op == BY_INCFSZ) && (inc == DATA_RST))
               || (is_bit && (bit_op == BT_TSTC) && !bit_val)
               || (is_bit && (bit_op == BT_TSTS) && bit_val);
  wire pc_hit   = is_jump || is_ret || (is_lit && (insn[13:10] == 4'hd));

  // Literal group: 11-bit targets for jump/call, 8-bit data otherwise
  wire lit_wwr = is_lit && !is_jump;

  // ------------------------------------------------------------------
  // Cycle control
  // ------------------------------------------------------------------
  wire exec = cyc_end && !flush;

  assign next_flush = cyc_end ? (!flush && (skip_hit || pc_hit)) : flush;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flush <= 1'b0;
    end else begin
      flush <= next_flush;
    end
  end

  assign insn_fetch = cyc_beg;
  assign phase_end  = cyc_end;
  assign file_rd    = cyc_beg && !flush && names_f;

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fields      <= '{group: MIFD_GRP_LIT, default: '0};
      file_addr   <= '0;
      wb          <= '0;
      carry_out   <= 1'b0;
      pc_load     <= 1'b0;
      skip_next   <= 1'b0;
      nop_cycle   <= 1'b0;
      port_a_read <= 1'b0;
    end else begin
      wb.fwr      <= 1'b0;
      wb.wwr      <= 1'b0;
      pc_load     <= 1'b0;
      skip_next   <= 1'b0;
      port_a_read <= 1'b0;
      if (cyc_end) begin
        // Raised at the edge that takes the skip, so it covers the discarded cycle
        nop_cycle <= next_flush;
      end
      if (exec) begin
        fields.group   <= grp_e;
        fields.opcode  <= is_bit ? {2'h0, bit_op} : insn[BYOP_LSB +: 4];
        fields.faddr   <= f_addr;
        fields.dest_f  <= d_bit;
        fields.bitn    <= b_num;
        // Don't-care bits never reach a result: literal masks drop them
        fields.literal <= is_jump ? lit11 : {3'h0, lit8};
        file_addr      <= f_addr;
        wb.fwr         <= byte_fwr || bit_wr;
        wb.wwr         <= byte_wwr || lit_wwr;
        wb.result      <= is_bit ? bit_res : (is_lit ? lit8 : (clrw ? DATA_RST : byte_res));
        carry_out      <= byte_c;
        pc_load        <= pc_hit;
        skip_next      <= skip_hit;
        // Implicit read of port A ends the change mismatch
        port_a_read    <= names_f && is_port;
      end
    end
  end

endmodule : mifd_decode

/* mifd_decode_asserts.sv */
`timescale 1ns/1ps
module mifd_chk
  import mifd_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic                      insn_fetch,
  input wire logic                      phase_end,
  input wire logic                      file_rd,
  input wire logic [mifd_pkg::ADDR_W-1:0] file_addr,
  input wire mifd_pkg::mifd_wb_s        wb,
  input wire logic                      pc_load,
  input wire logic                      skip_next,
  input wire logic                      nop_cycle,
  input wire logic                      port_a_read
);
  // ------------------------------------------------------------------
  // Timing and write-back checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_gap;
    !phase_end [*3] ##1 phase_end;
  endsequence
  sequence s_nop;
    nop_cycle [*4] ##1 !nop_cycle;
  endsequence
  a_phase_gap: assert property (phase_end |=> s_gap)
    else $error("phase spacing wrong");
  a_fetch_next: assert property (phase_end |=> insn_fetch)
    else $error("fetch not after last phase");
  a_nop_hold: assert property ($rose(nop_cycle) |-> s_nop)
    else $error("nop cycle length wrong");
  a_skip_nop: assert property ((skip_next || pc_load) |-> nop_cycle)
    else $error("no nop after skip or jump");
  a_nop_quiet: assert property ((nop_cycle && !$past(phase_end)) |-> !(wb.fwr || wb.wwr || pc_load))
    else $error("activity in nop cycle");
  a_wb_phase: assert property ((wb.fwr || wb.wwr) |-> $past(phase_end))
    else $error("write-back off phase");
  a_one_dest: assert property (!(wb.fwr && wb.wwr))
    else $error("both destinations written");
  a_rd_fetch: assert property (file_rd |-> insn_fetch && !nop_cycle)
    else $error("file read off phase");
  a_port_addr: assert property (port_a_read |-> file_addr == PORT_A_ADDR)
    else $error("port read at wrong address");
endmodule : mifd_chk

/* mifd_pkg.sv */
package mifd_pkg;

  // ------------------------------------------------------------------
  // Word format
  // ------------------------------------------------------------------
  localparam int INSN_W      = 14;
  localparam int ADDR_W      = 7;
  localparam int BITN_W      = 3;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int DATA_W      = 8;
  localparam int ADDR_LSB    = 0;
  localparam int DEST_POS    = 7;
  localparam int BITN_LSB    = 7;
  localparam int GRP_LSB     = 12;
  localparam int BOP_LSB     = 10;
  localparam int BYOP_LSB    = 8;
  localparam int JMP_POS     = 11;

  // ------------------------------------------------------------------
  // Group and operation codes
  // ------------------------------------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;

  localparam logic [3:0] BY_MOVWF  = 4'h0;
  localparam logic [3:0] BY_CLR    = 4'h1;
  localparam logic [3:0] BY_SUBWF  = 4'h2;
  localparam logic [3:0] BY_DECF   = 4'h3;
  localparam logic [3:0] BY_IORWF  = 4'h4;
  localparam logic [3:0] BY_ANDWF  = 4'h5;
  localparam logic [3:0] BY_XORWF  = 4'h6;
  localparam logic [3:0] BY_ADDWF  = 4'h7;
  localparam logic [3:0] BY_MOVF   = 4'h8;
  localparam logic [3:0] BY_COMF   = 4'h9;
  localparam logic [3:0] BY_INCF   = 4'ha;
  localparam logic [3:0] BY_DECFSZ = 4'hb;
  localparam logic [3:0] BY_RRF    = 4'hc;
  localparam logic [3:0] BY_RLF    = 4'hd;
  localparam logic [3:0] BY_SWAPF  = 4'he;
  localparam logic [3:0] BY_INCFSZ = 4'hf;

  localparam logic [1:0] BT_CLR  = 2'h0;
  localparam logic [1:0] BT_SET  = 2'h1;
  localparam logic [1:0] BT_TSTC = 2'h2;
  localparam logic [1:0] BT_TSTS = 2'h3;

  localparam logic [6:0] CTL_RETURN = 7'h08;
  localparam logic [6:0] CTL_RETFIE = 7'h09;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          OSC_PER_CYC = 4;
  localparam logic [1:0]  PH_LAST     = 2'(OSC_PER_CYC - 1);
  localparam logic [1:0]  PH_RST      = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_A_ADDR = 7'h05;

  typedef enum logic [2:0] {
    MIFD_GRP_BYTE = 3'b001,
    MIFD_GRP_BIT  = 3'b010,
    MIFD_GRP_LIT  = 3'b100
  } mifd_group_e;

  typedef struct packed {
    mifd_group_e               group;
    logic [3:0]                opcode;
    logic [ADDR_W-1:0]         faddr;
    logic                      dest_f;
    logic [BITN_W-1:0]         bitn;
    logic [LIT11_W-1:0]        literal;
  } mifd_fields_s;

  typedef struct packed {
    logic              fwr;
    logic              wwr;
    logic [DATA_W-1:0] result;
  } mifd_wb_s;

endpackage : mifd_pkg

/* mifd_pmem.sv */
`timescale 1ns/1ps
module mifd_pmem
  import mifd_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        phase_end,
  input  wire logic [mifd_pkg::INSN_W-1:0] next_word,
  output logic      [mifd_pkg::INSN_W-1:0] insn
);
  // Word held for a whole cycle, swapped only at the cycle boundary
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) insn <= '0;
    else if (phase_end) insn <= next_word;
  end
endmodule : mifd_pmem

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import mifd_pkg::*;
  logic clk = 0, arst_n = 0;
  logic [INSN_W-1:0] nw = '0, insn;
  logic [DATA_W-1:0] win = '0, rdata = '0, pins = '0;
  logic insn_fetch, phase_end, file_rd, carry_out, pc_load, skip_next, nop_cycle, port_a_read;
  logic [ADDR_W-1:0] file_addr;
  mifd_fields_s fields;
  mifd_wb_s wb;
  int failures = 0, cmp_count = 0, cyc = 0;
  logic rd_seen;
  always #2.5 clk = ~clk;
  mifd_pmem pm_u (.clk(clk), .arst_n(arst_n), .phase_end(phase_end), .next_word(nw), .insn(insn));
  mifd_decode dut_u (.clk(clk), .arst_n(arst_n), .insn(insn), .w_in(win), .carry_in(1'b0),
    .file_rdata(rdata), .port_pins(pins), .insn_fetch(insn_fetch), .phase_end(phase_end),
    .fields(fields), .file_rd(file_rd), .file_addr(file_addr), .wb(wb), .carry_out(carry_out),
    .pc_load(pc_load), .skip_next(skip_next), .nop_cycle(nop_cycle), .port_a_read(port_a_read));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (file_rd === 1'b1) rd_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_end();
    while (phase_end !== 1'b1) @(posedge clk) #1;
  endtask : wait_end
  // Word sits in the slot after a latch; results one edge past its end
  task automatic exec(input logic [INSN_W-1:0] w, input logic [INSN_W-1:0] nxt);
    wait_end();
    nw = w;
    @(posedge clk) #1;
    nw = nxt;
    rd_seen = 1'b0;
    wait_end();
    @(posedge clk) #1;
    nw = '0;
  endtask : exec
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_byte();
    win = 8'h03;
    rdata = 8'h04;
    exec(14'h0712, '0);
    chk("wwr", 1, wb.wwr);
    chk("fwr", 0, wb.fwr);
    chk("result", 8'h07, wb.result);
    chk("group", MIFD_GRP_BYTE, fields.group);
    chk("faddr", 7'h12, file_addr);
    chk("carry", 0, carry_out);
    exec(14'h0792, '0);
    chk("fwr d1", 1, wb.fwr);
    chk("rd", 1, rd_seen);
  endtask : t_byte
  task automatic t_clear();
    exec(14'h0185, '0);
    chk("clr rd", 1, rd_seen);
    chk("clr val", 8'h00, wb.result);
    chk("port rd", 1, port_a_read);
  endtask : t_clear
  task automatic t_bit();
    rdata = 8'h00;
    exec(14'h17a0, '0);
    chk("bset", 8'h80, wb.result);
    chk("bitn", 3'h7, fields.bitn);
    chk("group b", MIFD_GRP_BIT, fields.group);
  endtask : t_bit
  task automatic t_skip();
    rdata = 8'h01;
    exec(14'h1c21, 14'h3311);
    chk("skip", 1, skip_next);
    chk("nop", 1, nop_cycle);
    wait_end();
    @(posedge clk) #1;
    chk("discard", 0, wb.wwr);
  endtask : t_skip
  task automatic t_lit();
    exec(14'h2aa5, '0);
    chk("pcld", 1, pc_load);
    chk("k11", 11'h2a5, fields.literal);
    chk("group l", MIFD_GRP_LIT, fields.group);
    exec(14'h333c, '0);
    chk("k8", 8'h3c, wb.result);
    chk("wwr k", 1, wb.wwr);
  endtask : t_lit
  task automatic t_pins();
    rdata = 8'hff;
    pins = 8'h5a;
    exec(14'h0885, '0);
    chk("pins", 8'h5a, wb.result);
    chk("pins fwr", 1, wb.fwr);
    chk("port rd2", 1, port_a_read);
  endtask : t_pins
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    t_byte();
    t_clear();
    t_bit();
    t_skip();
    t_lit();
    t_pins();
    finish_test();
  end
endmodule : tb
bind mifd_decode mifd_chk chk_u (.clk(clk), .arst_n(arst_n), .insn_fetch(insn_fetch),
  .phase_end(phase_end), .file_rd(file_rd), .file_addr(file_addr), .wb(wb), .pc_load(pc_load),
  .skip_next(skip_next), .nop_cycle(nop_cycle), .port_a_read(port_a_read));
